// *** design/synth_pkg.sv ***
// Shared constants and types for the synthesizer serial load link.
// Summary of operation
// [RULE1] Eight-clock frame loads the configuration byte only.
// [RULE2] Fifteen or twenty-four clocks load reference divider.
// [RULE3] Sixteen-clock frame loads feedback divider only.
// [RULE4] Feedback load jam-loads both down-counters together.
// [RULE5] Bit 7 inverts single output, swaps pair.
// [RULE6] Bit 6 high: single output on, pair high.
// [RULE7] Bit 6 low: pair on, single output floats.
// [RULE8] Bit 5 low holds lock indicator low.
// [RULE9] Bits 4..2 choose reference output divide.
// [RULE10] Power-up clears configuration except divide-by-8 select.
// [RULE11] Bits 1,0 enable feedback and reference pulses.
// [RULE12] Single output pulses only while out of lock.
// [RULE13] Controller reruns initialisation after uncertain power-up.
// [RULE14] Count clocks during enable, decode at release.
package synth_pkg;
   // =========================================================
   // Configuration byte layout and reset value.
   localparam int CFG_INVERT = 7;
   localparam int CFG_SELECT = 6;
   localparam int CFG_LOCK_EN = 5;
   localparam int CFG_TAP_HI = 4;
   localparam int CFG_TAP_LO = 2;
   localparam int CFG_FB_EN = 1;
   localparam int CFG_REF_EN = 0;
   localparam logic [7:0] CFG_RESET = 8'h10;
   localparam logic [14:0] REF_DIV_RESET = 15'h0000;
   localparam logic [15:0] FB_DIV_RESET = 16'h0000;
   // =========================================================
   // Frame lengths in serial clocks.
   localparam logic [4:0] LEN_CONFIG = 5'h08;
   localparam logic [4:0] LEN_REF_SHORT = 5'h0F;
   localparam logic [4:0] LEN_REF_LONG = 5'h18;
   localparam logic [4:0] LEN_FEEDBACK = 5'h10;
   // =========================================================
   // Serial clock timing at 40 MHz system clock.
   localparam int CLK_PERIOD_NS = 25;
   localparam int SCLK_HALF_NS = 100;
   localparam int SCLK_HALF_CYC =
      (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // =========================================================
   // Controller register map.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_DATA = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam int CTRL_GO = 2;
   localparam int CTRL_INIT = 3;
   typedef enum logic [1:0] {
      KIND_CONFIG,
      KIND_REF_SHORT,
      KIND_REF_LONG,
      KIND_FEEDBACK
   } frame_kind_t;
endpackage : synth_pkg

// *** design/synth_link_if.sv ***
// Serial programming link between controller and synthesizer.
`timescale 1ns/1ps
interface synth_link_if;
   logic sclk;
   logic sdata;
   logic load_enable_n;
   modport device (
      input sclk,
      input sdata,
      input load_enable_n
   );
   modport host (
      output sclk,
      output sdata,
      output load_enable_n
   );
endinterface : synth_link_if

// *** design/synth_device.sv ***
// Synthesizer end: serial loader, divider registers, outputs.
`timescale 1ns/1ps
module synth_device (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   synth_link_if.device link,
   input wire logic oscillator_input,
   input wire logic feedback_input,
   output logic buffered_reference_output,
   output logic divided_reference_pulse,
   output logic divided_feedback_pulse,
   output logic lock_indicator,
   output logic single_ended_detector_out,
   output logic single_ended_detector_oe,
   output logic detector_ref_out,
   output logic detector_fb_out,
   output logic [7:0] output_configuration
);
   import synth_pkg::*;

   // =========================================================
   // Serial front end
   logic sclk_q;
   logic enable_q;
   logic [23:0] shift;
   logic [4:0] bit_count;
   logic sclk_rise;
   logic frame_end;
   logic [14:0] ref_divider;
   logic [15:0] fb_divider;
   logic jam_load;

   // Rising serial clock inside a frame, and the release of the enable.
   assign sclk_rise = link.sclk && !sclk_q && !link.load_enable_n;
   assign frame_end = link.load_enable_n && !enable_q;

   // Remembers last serial clock and enable levels for edge detection.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sclk_q <= 1'b0;
         enable_q <= 1'b1;
      end else if (ce) begin
         sclk_q <= link.sclk;
         enable_q <= link.load_enable_n;
      end
   end

   // Shifts data in and counts clocks while enable is low.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         shift <= 24'h00_0000;
         bit_count <= 5'h00;
      end else if (ce) begin
         if (link.load_enable_n) begin
            bit_count <= 5'h00; // see [RULE14]
         end else if (sclk_rise) begin
            shift <= {shift[22:0], link.sdata};
            if (bit_count != 5'h1F) begin
               bit_count <= bit_count + 5'h01; // see [RULE14]
            end
         end
      end
   end

   // Decodes destination from clock count at enable release.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         output_configuration <= CFG_RESET; // see [RULE10]
         ref_divider <= REF_DIV_RESET;
         fb_divider <= FB_DIV_RESET;
         jam_load <= 1'b0;
      end else if (ce) begin
         jam_load <= 1'b0;
         if (frame_end) begin
            if (bit_count == LEN_CONFIG) begin
               output_configuration <= shift[7:0]; // see [RULE1]
            end else if (bit_count == LEN_REF_SHORT ||
                         bit_count == LEN_REF_LONG) begin
               ref_divider <= shift[14:0]; // see [RULE2]
            end else if (bit_count == LEN_FEEDBACK) begin
               fb_divider <= shift[15:0]; // see [RULE3]
               jam_load <= 1'b1; // see [RULE4]
            end
            // Any other count is dropped, see [RULE14].
         end
      end
   end

   // =========================================================
   // Counters and reference tap
   logic osc_q;
   logic fin_q;
   logic osc_rise;
   logic fin_rise;
   logic [14:0] ref_count;
   logic [15:0] fb_count;
   logic ref_event;
   logic fb_event;
   logic [3:0] prescale;
   logic [2:0] tap_sel;

   assign osc_rise = oscillator_input && !osc_q;
   assign fin_rise = feedback_input && !fin_q;
   assign ref_event = osc_rise && ref_count <= 15'h0001;
   assign fb_event = fin_rise && fb_count <= 16'h0001;
   assign tap_sel = output_configuration[CFG_TAP_HI:CFG_TAP_LO];

   // Edge history of the oscillator and feedback inputs.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         osc_q <= 1'b0;
         fin_q <= 1'b0;
      end else if (ce) begin
         osc_q <= oscillator_input;
         fin_q <= feedback_input;
      end
   end

   // Down-counters; a feedback load restarts both at once.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ref_count <= REF_DIV_RESET;
         fb_count <= FB_DIV_RESET;
      end else if (ce) begin
         if (jam_load) begin
            ref_count <= ref_divider; // see [RULE4]
            fb_count <= fb_divider; // see [RULE4]
         end else begin
            if (osc_rise) begin
               ref_count <= ref_event ? ref_divider : ref_count - 15'h0001;
            end
            if (fin_rise) begin
               fb_count <= fb_event ? fb_divider : fb_count - 16'h0001;
            end
         end
      end
   end

   // Oscillator prescaler feeding the reference output taps.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prescale <= 4'h0;
      end else if (ce && osc_rise) begin
         prescale <= prescale + 4'h1;
      end
   end

   // Selects the reference output divide.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         buffered_reference_output <= 1'b0;
      end else if (ce) begin
         unique case (tap_sel) // see [RULE9]
            3'b000: buffered_reference_output <= 1'b0;
            3'b001: buffered_reference_output <= oscillator_input;
            3'b010: buffered_reference_output <= prescale[0];
            3'b011: buffered_reference_output <= prescale[1];
            3'b100,
            3'b110: buffered_reference_output <= prescale[2];
            3'b101,
            3'b111: buffered_reference_output <= prescale[3];
         endcase
      end
   end

   // =========================================================
   // Phase detector and gated outputs
   logic ref_ahead;
   logic fb_ahead;
   logic ref_pulse_q;
   logic fb_pulse_q;
   logic out_of_lock;
   logic invert;
   logic use_single;

   assign out_of_lock = ref_ahead || fb_ahead;
   assign invert = output_configuration[CFG_INVERT];
   assign use_single = output_configuration[CFG_SELECT];

   // Tracks which divided edge came first; cleared when both arrive.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ref_ahead <= 1'b0;
         fb_ahead <= 1'b0;
      end else if (ce) begin
         if (jam_load) begin
            ref_ahead <= 1'b0; // see [RULE4]
            fb_ahead <= 1'b0;
         end else begin
            if ((ref_event || ref_ahead) && (fb_event || fb_ahead)) begin
               ref_ahead <= 1'b0;
               fb_ahead <= 1'b0;
            end else begin
               ref_ahead <= ref_ahead || ref_event;
               fb_ahead <= fb_ahead || fb_event;
            end
         end
      end
   end

   // Divided pulses, one oscillator or feedback input period wide, held low when off.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ref_pulse_q <= 1'b0;
         fb_pulse_q <= 1'b0;
      end else if (ce) begin
         if (osc_rise) begin
            ref_pulse_q <= ref_event;
         end
         if (fin_rise) begin
            fb_pulse_q <= fb_event;
         end
      end
   end

   // Registered drive of all detector, lock and pulse pins.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         divided_reference_pulse <= 1'b0;
         divided_feedback_pulse <= 1'b0;
         lock_indicator <= 1'b0;
         single_ended_detector_out <= 1'b0;
         single_ended_detector_oe <= 1'b0;
         detector_ref_out <= 1'b1;
         detector_fb_out <= 1'b1;
      end else if (ce) begin
         divided_reference_pulse <= ref_pulse_q &&
            output_configuration[CFG_REF_EN]; // see [RULE11]
         divided_feedback_pulse <= fb_pulse_q &&
            output_configuration[CFG_FB_EN]; // see [RULE11]
         lock_indicator <= output_configuration[CFG_LOCK_EN] &&
            !out_of_lock; // see [RULE8]
         // Drives only while a correction is pending.
         single_ended_detector_oe <= use_single && out_of_lock; // see [RULE12]
         single_ended_detector_out <= ref_ahead ^ invert; // see [RULE5]
         if (use_single) begin
            detector_ref_out <= 1'b1; // see [RULE6]
            detector_fb_out <= 1'b1; // see [RULE6]
         end else begin
            // The pair is active; single output stays floating.
            detector_ref_out <= invert ? !fb_ahead : !ref_ahead; // see [RULE7]
            detector_fb_out <= invert ? !ref_ahead : !fb_ahead; // see [RULE5]
         end
      end
   end
endmodule : synth_device

// *** design/synth_host.sv ***
// Controller end: register port driving the serial load link.
`timescale 1ns/1ps
module synth_host (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   synth_link_if.host link,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);
   import synth_pkg::*;

   typedef enum logic [1:0] {IDLE, LOW_PHASE, HIGH_PHASE, RELEASE} state_t;

   state_t state;
   logic [23:0] data_reg;
   logic [23:0] shift;
   logic [4:0] bits_left;
   logic [7:0] timer;
   logic done;
   logic go;
   logic [4:0] next_len;
   logic timer_end;

   assign go = wr && addr == REG_CTRL && state == IDLE &&
      (wdata[CTRL_GO] || wdata[CTRL_INIT]);
   assign timer_end = timer == 8'(SCLK_HALF_CYC - 1);

   // Frame length from the requested kind.
   always_comb begin
      unique case (frame_kind_t'(wdata[1:0]))
         KIND_CONFIG: next_len = LEN_CONFIG; // see [RULE1]
         KIND_REF_SHORT: next_len = LEN_REF_SHORT; // see [RULE2]
         KIND_REF_LONG: next_len = LEN_REF_LONG; // see [RULE2]
         KIND_FEEDBACK: next_len = LEN_FEEDBACK; // see [RULE3]
      endcase
      if (wdata[CTRL_INIT]) begin
         next_len = LEN_CONFIG; // see [RULE13]
      end
   end

   // Data word written by software.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         data_reg <= 24'h00_0000;
      end else if (ce && wr && addr == REG_DATA) begin
         data_reg <= wdata[23:0];
      end
   end

   // Serial sequencer; data changes while the clock is low.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state <= IDLE;
         shift <= 24'h00_0000;
         bits_left <= 5'h00;
         timer <= 8'h00;
         link.sclk <= 1'b0;
         link.sdata <= 1'b0;
         link.load_enable_n <= 1'b1;
      end else if (ce) begin
         timer <= timer_end ? 8'h00 : timer + 8'h01;
         unique case (state)
            IDLE: begin
               timer <= 8'h00;
               if (go) begin
                  // Initialisation resends the power-up configuration.
                  shift <= wdata[CTRL_INIT] ? {16'h0000, CFG_RESET} :
                     data_reg; // see [RULE13]
                  bits_left <= next_len;
                  link.load_enable_n <= 1'b0;
                  state <= LOW_PHASE;
               end
            end
            LOW_PHASE: begin
               link.sdata <= shift[bits_left - 5'h01];
               if (timer_end) begin
                  link.sclk <= 1'b1;
                  bits_left <= bits_left - 5'h01;
                  state <= HIGH_PHASE;
               end
            end
            HIGH_PHASE: begin
               if (timer_end) begin
                  link.sclk <= 1'b0;
                  state <= bits_left == 5'h00 ? RELEASE : LOW_PHASE;
               end
            end
            RELEASE: begin
               if (timer_end) begin
                  link.load_enable_n <= 1'b1; // see [RULE14]
                  state <= IDLE;
               end
            end
         endcase
      end
   end

   // Sticky done flag; a finishing frame wins over the read clear.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         done <= 1'b0;
      end else if (ce) begin
         if (state == RELEASE && timer_end) begin
            done <= 1'b1;
         end else if (rd && addr == REG_STATUS) begin
            done <= 1'b0;
         end
      end
   end

   // Read data, valid the cycle after the strobe.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdata <= 32'h0000_0000;
      end else if (ce) begin
         rdata <= 32'h0000_0000;
         if (rd && addr == REG_DATA) begin
            rdata <= {8'h00, data_reg};
         end else if (rd && addr == REG_STATUS) begin
            rdata <= {30'h0000_0000, done, state != IDLE};
         end
      end
   end
endmodule : synth_host

// *** test/synth_link_chk.sv ***
// Concurrent checks on the serial load link and the device outputs.
`timescale 1ns/1ps
module synth_link_chk (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic load_enable_n,
   input wire logic [7:0] output_configuration,
   input wire logic buffered_reference_output,
   input wire logic divided_reference_pulse,
   input wire logic divided_feedback_pulse,
   input wire logic lock_indicator,
   input wire logic single_ended_detector_oe,
   input wire logic detector_ref_out,
   input wire logic detector_fb_out
);
   import synth_pkg::*;
   // =========================================================
   // Link framing.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   // Serial clock rests low outside a frame.
   a_sclk_idle_low: assert property (load_enable_n |-> !sclk)
      else $error("serial clock high outside a frame");
   // The high half of the serial clock lasts four system cycles.
   a_sclk_high_hold: assert property (
      $rose(sclk) |-> sclk[*4])
      else $error("serial clock high half too short");
   // Serial data holds still while the clock is high.
   a_data_steady: assert property (
      sclk && $past(sclk) |-> $stable(sdata))
      else $error("serial data moved while clock high");
   // =========================================================
   // Configuration byte and the outputs it gates.
   a_cfg_power_up: assert property (
      $rose(nrst) |-> output_configuration == CFG_RESET)
      else $error("configuration not at power-up value");
   a_cfg_after_frame: assert property (
      !$stable(output_configuration) |->
      load_enable_n && !$past(load_enable_n, 4))
      else $error("configuration changed outside a frame end");
   a_pair_parked: assert property (
      output_configuration[CFG_SELECT][*4] |->
      detector_ref_out && detector_fb_out)
      else $error("detector pair not held high");
   a_single_floats: assert property (
      (!output_configuration[CFG_SELECT])[*4] |->
      !single_ended_detector_oe)
      else $error("single detector output driven while off");
   a_lock_gated: assert property (
      (!output_configuration[CFG_LOCK_EN])[*4] |-> !lock_indicator)
      else $error("lock indicator high while disabled");
   a_fb_pulse_gated: assert property (
      (!output_configuration[CFG_FB_EN])[*4] |-> !divided_feedback_pulse)
      else $error("feedback pulse high while disabled");
   a_ref_pulse_gated: assert property (
      (!output_configuration[CFG_REF_EN])[*4] |-> !divided_reference_pulse)
      else $error("reference pulse high while disabled");
   a_tap_static: assert property (
      (output_configuration[CFG_TAP_HI:CFG_TAP_LO] == 3'b000)[*4] |->
      !buffered_reference_output)
      else $error("reference output not static low");
   // A driven single output never coexists with a lock report.
   a_single_lock_excl: assert property (
      !(single_ended_detector_oe && lock_indicator))
      else $error("single detector output driven while locked");
endmodule : synth_link_chk

// *** test/synth_config_and_load_control_tb.sv ***
// Self-checking bench joining the host and device ends of the load link.
`timescale 1ns/1ps
module synth_config_and_load_control_tb;
   import synth_pkg::*;
   `define CHECK(nm, e, v) begin total_checks++; if ((v) !== (e)) begin \
      err_count++; $display("mismatch %s exp %h got %h", nm, e, v); end end
   typedef struct {string name; logic [1:0] sel; logic [31:0] exp;
      logic [31:0] mask;} note_t;
   note_t notes[$];
   note_t cur;
   int err_count = 0;
   int total_checks = 0;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic oscillator_input = 1'b0;
   logic feedback_input = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0, rd = 1'b0, rd_chk = 1'b0, rd_q = 1'b0, probe = 1'b0;
   logic [31:0] rdata, got, edge_cnt;
   logic [31:0] rnd = 32'h0001_1C13;
   logic [7:0] output_configuration;
   logic buffered_reference_output, divided_reference_pulse;
   logic divided_feedback_pulse, lock_indicator, single_ended_detector_out;
   logic single_ended_detector_oe, detector_ref_out, detector_fb_out;
   logic [31:0] obs;
   // Output snapshot seen by the monitor.
   assign obs = {16'h0000, single_ended_detector_out, output_configuration,
      single_ended_detector_oe,
      detector_ref_out, detector_fb_out, lock_indicator,
      divided_feedback_pulse, divided_reference_pulse,
      buffered_reference_output};
   synth_link_if link ();
   synth_host synth_host_inst (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
      .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata));
   synth_device synth_device_inst (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
      .link(link), .oscillator_input(oscillator_input),
      .feedback_input(feedback_input),
      .buffered_reference_output(buffered_reference_output),
      .divided_reference_pulse(divided_reference_pulse),
      .divided_feedback_pulse(divided_feedback_pulse),
      .lock_indicator(lock_indicator),
      .single_ended_detector_out(single_ended_detector_out),
      .single_ended_detector_oe(single_ended_detector_oe),
      .detector_ref_out(detector_ref_out),
      .detector_fb_out(detector_fb_out),
      .output_configuration(output_configuration));
   synth_link_chk synth_link_chk_inst (.clk_sys(clk_sys), .nrst(nrst),
      .sclk(link.sclk), .sdata(link.sdata),
      .load_enable_n(link.load_enable_n),
      .output_configuration(output_configuration),
      .buffered_reference_output(buffered_reference_output),
      .divided_reference_pulse(divided_reference_pulse),
      .divided_feedback_pulse(divided_feedback_pulse),
      .lock_indicator(lock_indicator),
      .single_ended_detector_oe(single_ended_detector_oe),
      .detector_ref_out(detector_ref_out),
      .detector_fb_out(detector_fb_out));
   // =========================================================
   // Clock, oscillator and feedback stimulus.
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      oscillator_input <= ~oscillator_input;
      feedback_input <= rnd[3];
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // =========================================================
   // Monitor: takes the oldest note whenever a result appears.
   always @(posedge clk_sys) begin
      rd_q <= rd & rd_chk;
      if (rd_q | probe) begin
         cur = notes.pop_front();
         got = (cur.sel == 2'd0) ? rdata :
            (cur.sel == 2'd1) ? (obs & cur.mask) : edge_cnt;
         `CHECK(cur.name, cur.exp, got)
      end
   end
   task automatic finish_test();
      if (err_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   // =========================================================
   // Register port cycles and probes.
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, input logic chk,
      input logic [31:0] e, output logic [31:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      rd_chk <= chk;
      if (chk) notes.push_back('{"rdata", 2'd0, e, 32'hFFFF_FFFF});
      @(posedge clk_sys);
      rd <= 1'b0;
      rd_chk <= 1'b0;
      @(posedge clk_sys);
      v = rdata;
   endtask : rd_reg
   task automatic look(input string nm, input logic [1:0] sel,
      input logic [31:0] e, input logic [31:0] m);
      @(posedge clk_sys);
      notes.push_back('{nm, sel, e, m});
      probe <= 1'b1;
      @(posedge clk_sys);
      probe <= 1'b0;
   endtask : look
   task automatic wait_done();
      logic [31:0] v;
      int i;
      for (i = 0; i < 200; i++) begin
         rd_reg(REG_STATUS, 1'b0, 32'h0000_0000, v);
         if (v[1] === 1'b1) break;
      end
      if (i == 200) begin
         err_count++;
         finish_test();
      end
   endtask : wait_done
   task automatic send(input logic [1:0] kind, input logic [31:0] d);
      wr_reg(REG_DATA, d);
      wr_reg(REG_CTRL, {30'h0000_0000, kind} | (32'h1 << CTRL_GO));
      wait_done();
   endtask : send
   // Counts rising edges of one snapshot bit over 512 settled cycles.
   task automatic count_rises(input int b);
      logic prev;
      int j;
      repeat (64) @(posedge clk_sys);
      edge_cnt = 0;
      prev = obs[b];
      for (j = 0; j < 512; j++) begin
         @(posedge clk_sys);
         if (obs[b] && !prev) edge_cnt++;
         prev = obs[b];
      end
   endtask : count_rises
   // =========================================================
   // Main sequence.
   initial begin
      int k;
      int taps[8];
      logic [31:0] v;
      logic [7:0] cfg;
      taps = '{0, 256, 128, 64, 32, 16, 32, 16};
      look("reset_out", 2'd1, 32'h0000_0830, 32'h0000_FFFE);
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      cfg = CFG_RESET;
      for (k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         send(k[1:0], rnd & 32'h00FF_FFFF);
         if (k == 0) cfg = rnd[7:0];
         look("cfg", 2'd1, {cfg, 7'h00}, 32'h0000_7F80);
         rd_reg(REG_DATA, 1'b1, rnd & 32'h00FF_FFFF, v);
      end
      wr_reg(REG_DATA, 32'h0000_00A5);
      wr_reg(REG_CTRL, 32'h0000_0003 | (32'h1 << CTRL_GO));
      wr_reg(REG_CTRL, 32'h0000_0000 | (32'h1 << CTRL_GO));
      rd_reg(REG_STATUS, 1'b1, 32'h0000_0001, v);
      wait_done();
      rd_reg(REG_STATUS, 1'b1, 32'h0000_0000, v);
      look("cfg_kept", 2'd1, {cfg, 7'h00}, 32'h0000_7F80);
      send(KIND_CONFIG, 32'h0000_0040);
      repeat (16) @(posedge clk_sys);
      look("single_on", 2'd1, 32'h0000_0030, 32'h0000_003E);
      send(KIND_CONFIG, 32'h0000_0000);
      repeat (16) @(posedge clk_sys);
      look("all_off", 2'd1, 32'h0000_0000,
         32'h0000_004F);
      for (k = 0; k < 8; k++) begin
         send(KIND_CONFIG, {27'h000_0000, k[2:0], 2'b00});
         count_rises(0);
         look("ref_edges", 2'd2, taps[k], 32'hFFFF_FFFF);
      end
      // Reference pulse period follows both reference frame lengths,
      // once a feedback frame has restarted the counters.
      send(KIND_CONFIG, 32'h0000_0001);
      send(KIND_REF_SHORT, 32'h0000_0004);
      send(KIND_FEEDBACK, 32'h0000_0100);
      count_rises(1);
      look("ref_short", 2'd2, 32'h0000_0040, 32'hFFFF_FFFF);
      send(KIND_REF_LONG, 32'h00AB_0008);
      send(KIND_FEEDBACK, 32'h0000_0100);
      count_rises(1);
      look("ref_long", 2'd2, 32'h0000_0020, 32'hFFFF_FFFF);
      wr_reg(REG_CTRL, 32'h1 << CTRL_INIT);
      wait_done();
      look("cfg_init", 2'd1, 32'h0000_0800, 32'h0000_7F80);
      rd_reg(4'hC, 1'b1, 32'h0000_0000, v);
      // Leave a non-default byte in place so the reset has work to do.
      send(KIND_CONFIG, 32'h0000_00E3);
      repeat (16) @(posedge clk_sys);
      look("pair_parked", 2'd1, 32'h0000_0030, 32'h0000_0031);
      nrst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      look("cfg_reset", 2'd1, 32'h0000_0800, 32'h0000_7F80);
      repeat (4) @(posedge clk_sys);
      finish_test();
   end
endmodule : synth_config_and_load_control_tb
